/* File: pae_pkg.sv */
package pae_pkg;

	// ============================================================
	// Sizes
	localparam int NUM_ALARMS = 3;
	localparam int VAL_W      = 16;
	localparam int EXT_W      = 18;
	localparam int PER_W      = 10;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int BYTE_W     = 8;
	localparam int STRB_W     = DATA_W / BYTE_W;
	localparam int SEL_W      = 2;
	localparam int CODE_W     = 4;

	typedef logic signed [VAL_W-1:0] pae_val_t;
	typedef logic signed [EXT_W-1:0] pae_ext_t;
	typedef logic [VAL_W-1:0]        pae_hys_t;
	typedef logic [PER_W-1:0]        pae_per_t;
	typedef logic [SEL_W-1:0]        pae_sel_t;

	// ============================================================
	// Alarm type codes
	typedef enum logic [CODE_W-1:0] {
		CODE_OFF       = 4'b0000,
		CODE_BAND      = 4'b0001,
		CODE_UPPER     = 4'b0010,
		CODE_LOWER     = 4'b0011,
		CODE_RANGE     = 4'b0100,
		CODE_BAND_SB   = 4'b0101,
		CODE_UPPER_SB  = 4'b0110,
		CODE_LOWER_SB  = 4'b0111,
		CODE_ABS_HI    = 4'b1000,
		CODE_ABS_LO    = 4'b1001,
		CODE_ABS_HI_SB = 4'b1010,
		CODE_ABS_LO_SB = 4'b1011,
		CODE_LOOP      = 4'b1100,
		CODE_RATE      = 4'b1101
	} pae_code_t;

	localparam pae_code_t CODE_RESET = CODE_UPPER;
	localparam pae_per_t  PER_MIN    = 10'h001;
	localparam pae_per_t  PER_MAX    = 10'h3e7;
	localparam pae_per_t  PER_RESET  = 10'h004;

	// ============================================================
	// Timing
	localparam int unsigned SAMPLE_MS         = 250;
	localparam int unsigned CLK_PERIOD_NS     = 5;
	localparam int unsigned SAMPLE_CYCLES_DOC = SAMPLE_MS * 1000000 / CLK_PERIOD_NS;

	// ============================================================
	// Register map
	localparam logic [ADDR_W-1:0] OFS_TARGET   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATE    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ASSIGN   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MEAS     = 8'h18;
	localparam int                ALM_SHIFT    = 5;
	localparam int                WIN_W        = ADDR_W - ALM_SHIFT;
	localparam logic [ALM_SHIFT-1:0] SUB_TYPE  = 5'h00;
	localparam logic [ALM_SHIFT-1:0] SUB_UPPER = 5'h04;
	localparam logic [ALM_SHIFT-1:0] SUB_LOWER = 5'h08;
	localparam logic [ALM_SHIFT-1:0] SUB_HYST  = 5'h0c;
	localparam logic [ALM_SHIFT-1:0] SUB_PER   = 5'h10;
	localparam int                CO_LSB0      = 0;
	localparam int                CO_LSB1      = 4;
	localparam logic [1:0]        RESP_OKAY    = 2'h0;
	localparam logic [1:0]        RESP_SLVERR  = 2'h2;

endpackage

/* File: pae_alarm_eval.sv */
`timescale 1ns/1ps
module pae_alarm_eval (
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// Sampling and control
	input  wire logic               tick,
	input  wire logic               restart,
	input  wire pae_pkg::pae_code_t code,
	// Process values and thresholds
	input  wire pae_pkg::pae_val_t  measured_value,
	input  wire pae_pkg::pae_val_t  target_value,
	input  wire pae_pkg::pae_val_t  upper_value,
	input  wire pae_pkg::pae_val_t  lower_value,
	input  wire pae_pkg::pae_hys_t  hysteresis,
	input  wire pae_pkg::pae_per_t  period,
	input  wire logic               loop_break_detect,
	// Result
	output logic                    alarm
);
	import pae_pkg::*;

	typedef struct packed {
		logic     active;
		logic     standby;
		logic     out;
		pae_val_t prev;
		pae_per_t cnt;
	} pae_eval_st_t;

	pae_eval_st_t st;
	pae_eval_st_t next_st;
	pae_code_t    base;
	logic         sb_type;
	logic         raw;
	logic         overlap;
	logic         period_end;
	pae_ext_t     pv;
	pae_ext_t     xv;
	pae_ext_t     lv;
	pae_ext_t     hv;
	pae_ext_t     dev;
	pae_ext_t     rate;

	// Once on, a compare only releases after backing off by the hysteresis
	function automatic logic above(input pae_ext_t q, input pae_ext_t t, input pae_ext_t h, input logic act);
		above = act ? (q > t - h) : (q > t);
	endfunction

	function automatic logic below(input pae_ext_t q, input pae_ext_t t, input pae_ext_t h, input logic act);
		below = act ? (q < t + h) : (q < t);
	endfunction

	// ============================================================
	// Evaluation
	always_comb begin
		pv      = pae_ext_t'(measured_value);
		xv      = pae_ext_t'(upper_value);
		lv      = pae_ext_t'(lower_value);
		hv      = pae_ext_t'(hysteresis);
		dev     = pv - pae_ext_t'(target_value);
		rate    = pv - pae_ext_t'(st.prev);
		overlap = (xv - hv) <= (hv - lv);
		sb_type = 1'b1;
		case (code)
			CODE_BAND_SB:   base = CODE_BAND;
			CODE_UPPER_SB:  base = CODE_UPPER;
			CODE_LOWER_SB:  base = CODE_LOWER;
			CODE_ABS_HI_SB: base = CODE_ABS_HI;
			CODE_ABS_LO_SB: base = CODE_ABS_LO;
			default: begin
				base    = code;
				sb_type = 1'b0;
			end
		endcase
		next_st    = st;
		raw        = st.active;
		period_end = st.cnt >= period - PER_MIN;
		if (restart) begin
			next_st.active  = 1'b0;
			next_st.standby = 1'b1;
			next_st.cnt     = '0;
			next_st.prev    = measured_value;
		end else if (tick) begin
			case (base)
				CODE_OFF:    raw = 1'b0;
				CODE_BAND:   raw = above(dev, xv, hv, st.active) | below(dev, -lv, hv, st.active);
				CODE_UPPER:  raw = above(dev, xv, hv, st.active);
				CODE_LOWER:  raw = below(dev, -xv, hv, st.active);
				CODE_RANGE:  raw = st.active ? (dev < xv + hv && dev > -lv - hv) : (dev < xv && dev > -lv);
				CODE_ABS_HI: raw = above(pv, xv, hv, st.active);
				CODE_ABS_LO: raw = below(pv, xv, hv, st.active);
				CODE_LOOP:   raw = loop_break_detect;
				CODE_RATE: begin
					// Sign of the threshold picks the direction watched
					if (period_end) begin
						raw = xv[EXT_W-1] ? below(rate, xv, hv, st.active) : above(rate, xv, hv, st.active);
					end
				end
				default:     raw = 1'b0;
			endcase
			if (code == CODE_BAND_SB && overlap) begin
				raw = 1'b0;
			end
			next_st.active = raw;
			if (!raw) begin
				next_st.standby = 1'b0;
			end
			if (period_end) begin
				next_st.cnt  = '0;
				next_st.prev = measured_value;
			end else begin
				next_st.cnt = st.cnt + PER_MIN;
			end
		end
		next_st.out = next_st.active & ~(sb_type & next_st.standby);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st         <= '0;
			st.standby <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign alarm = st.out;

	// ============================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_off_quiet: assert property (tick && !restart && code == CODE_OFF |=> !alarm)
		else $error("Alarm on while its type is off");
	a_upper_set: assert property (tick && !restart && code == CODE_UPPER && dev > xv |=> alarm)
		else $error("Upper deviation alarm missed");
	a_lower_set: assert property (tick && !restart && code == CODE_LOWER && dev < -xv |=> alarm)
		else $error("Lower deviation alarm missed");
	a_range_inside: assert property (tick && !restart && code == CODE_RANGE && dev < xv && dev > -lv |=> alarm)
		else $error("Inside range alarm missed");
	a_abs_high: assert property (tick && !restart && code == CODE_ABS_HI && pv > xv |=> alarm)
		else $error("Absolute upper alarm missed");
	a_abs_low: assert property (tick && !restart && code == CODE_ABS_LO && pv < xv |=> alarm)
		else $error("Absolute lower alarm missed");
	a_band_overlap: assert property (tick && !restart && code == CODE_BAND_SB && overlap |=> !alarm)
		else $error("Overlapping band alarm not held off");
	a_standby_hold: assert property (tick && !restart && sb_type && st.standby |=> !alarm)
		else $error("Standby alarm fired before first clear");
	a_upper_keep: assert property (tick && !restart && code == CODE_UPPER && alarm && dev > xv - hv |=> alarm)
		else $error("Upper alarm released inside hysteresis");

endmodule

/* File: pae_alarm_top.sv */
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Function
// - Each alarm has its own type; all reset to deviation upper limit.
// - Output depends on type, threshold, hysteresis and standby state.
// - Type 0 never alarms; type 2 alarms above target plus threshold.
// - Type 3 alarms below target minus threshold.
// - Type 1 alarms outside the band of upper and lower deviation limits.
// - Type 4 alarms while inside the band around the target.
// - Types 1, 4, 5 use separate upper and lower limits per alarm.
// - Type 8 alarms when measured value exceeds threshold, target ignored.
// - Type 9 alarms when measured value is below threshold, target ignored.
// - Types 5, 6, 7, 10, 11 mirror 1, 2, 3, 8, 9 with standby.
// - Type 5 stays off when the two hysteresis bands overlap.
// - Type 12 is loop break, accepted only for the first alarm.
// - Type 13 is the measured value rate of change alarm.
// - Either control output can carry any alarm instead of control action.
// - Rate difference taken every 1 to 999 samples, default 4.
// - Positive rate threshold watches rises, negative watches falls.
module pae_alarm_top #(
	parameter int unsigned SAMPLE_CYCLES = pae_pkg::SAMPLE_CYCLES_DOC
) (
	// Clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// AXI4-Lite write channels
	input  wire logic [pae_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [pae_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [pae_pkg::STRB_W-1:0]   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [pae_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [pae_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	// Process side
	input  wire pae_pkg::pae_val_t            measured_value,
	input  wire logic                         loop_break_detect,
	input  wire logic [1:0]                   control_in,
	// Results
	output logic [pae_pkg::NUM_ALARMS-1:0]    alarm_out,
	output logic [1:0]                        control_out,
	output logic                              irq
);
	import pae_pkg::*;

	localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);
	localparam int AI_W  = $clog2(NUM_ALARMS);

	if (SAMPLE_CYCLES < 1) begin : g_bad_sample
		$error("SAMPLE_CYCLES must be at least one");
	end

	typedef struct packed {
		logic [ADDR_W-1:0]          awaddr;
		logic                       aw_got;
		logic [DATA_W-1:0]          wdata;
		logic [STRB_W-1:0]          wstrb;
		logic                       w_got;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [1:0]                 rresp;
		logic [DATA_W-1:0]          rdata;
		pae_val_t                   target;
		pae_val_t                   meas;
		pae_code_t [NUM_ALARMS-1:0] atype;
		pae_val_t [NUM_ALARMS-1:0]  aupper;
		pae_val_t [NUM_ALARMS-1:0]  alower;
		pae_hys_t [NUM_ALARMS-1:0]  ahyst;
		pae_per_t [NUM_ALARMS-1:0]  aper;
		logic [NUM_ALARMS-1:0]      restart;
		pae_sel_t [1:0]             co_sel;
		logic [NUM_ALARMS-1:0]      irq_stat;
		logic [NUM_ALARMS-1:0]      irq_en;
		logic [NUM_ALARMS-1:0]      alarm_d;
		logic [CNT_W-1:0]           scnt;
		logic                       tick;
		logic [1:0]                 ctrl;
		logic                       irq;
	} pae_top_st_t;

	pae_top_st_t           st;
	pae_top_st_t           next_st;
	logic [DATA_W:0]       rd;
	logic [DATA_W:0]       wr_old;
	logic [DATA_W-1:0]     wv;
	logic [NUM_ALARMS-1:0] clr;
	logic [NUM_ALARMS-1:0] rise;
	logic [WIN_W-1:0]      win;
	logic [AI_W-1:0]       ai;

	// Top bit of the result flags a mapped address
	function automatic logic [DATA_W:0] reg_read(input pae_top_st_t s, input logic [ADDR_W-1:0] a,
		input logic [NUM_ALARMS-1:0] al);
		logic [DATA_W-1:0] d;
		logic              hit;
		logic [WIN_W-1:0]  w;
		logic [AI_W-1:0]   k;
		d   = '0;
		hit = 1'b1;
		w   = a[ADDR_W-1:ALM_SHIFT];
		k   = AI_W'(w - WIN_W'(1));
		case (a)
			OFS_TARGET:   d[VAL_W-1:0] = s.target;
			OFS_STATE:    d[NUM_ALARMS-1:0] = al;
			OFS_ASSIGN: begin
				d[CO_LSB0 +: SEL_W] = s.co_sel[0];
				d[CO_LSB1 +: SEL_W] = s.co_sel[1];
			end
			OFS_IRQ_STAT: d[NUM_ALARMS-1:0] = s.irq_stat;
			OFS_IRQ_CLR:  d = '0;
			OFS_IRQ_EN:   d[NUM_ALARMS-1:0] = s.irq_en;
			OFS_MEAS:     d[VAL_W-1:0] = s.meas;
			default: begin
				if (w >= WIN_W'(1) && w <= WIN_W'(NUM_ALARMS)) begin
					case (a[ALM_SHIFT-1:0])
						SUB_TYPE:  d[CODE_W-1:0] = s.atype[k];
						SUB_UPPER: d[VAL_W-1:0] = s.aupper[k];
						SUB_LOWER: d[VAL_W-1:0] = s.alower[k];
						SUB_HYST:  d[VAL_W-1:0] = s.ahyst[k];
						SUB_PER:   d[PER_W-1:0] = s.aper[k];
						default:   hit = 1'b0;
					endcase
				end else begin
					hit = 1'b0;
				end
			end
		endcase
		reg_read = {hit, d};
	endfunction

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
		input logic [STRB_W-1:0] strb);
		merge = old;
		for (int b = 0; b < STRB_W; b++) begin
			if (strb[b]) begin
				merge[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
			end
		end
	endfunction

	assign s_axi_awready = !st.aw_got && !st.bvalid;
	assign s_axi_wready  = !st.w_got && !st.bvalid;
	assign s_axi_arready = !st.rvalid;

	// ============================================================
	// Bus, configuration, sampling and interrupts
	always_comb begin
		next_st         = st;
		next_st.restart = '0;
		next_st.tick    = 1'b0;
		clr             = '0;
		rd              = '0;
		wr_old          = reg_read(st, st.awaddr, alarm_out);
		wv              = merge(wr_old[DATA_W-1:0], st.wdata, st.wstrb);
		win             = st.awaddr[ADDR_W-1:ALM_SHIFT];
		ai              = AI_W'(win - WIN_W'(1));
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.awaddr = s_axi_awaddr;
			next_st.aw_got = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
			next_st.w_got = 1'b1;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = wr_old[DATA_W] ? RESP_OKAY : RESP_SLVERR;
			case (st.awaddr)
				OFS_TARGET: next_st.target = pae_val_t'(wv[VAL_W-1:0]);
				OFS_ASSIGN: begin
					next_st.co_sel[0] = wv[CO_LSB0 +: SEL_W];
					next_st.co_sel[1] = wv[CO_LSB1 +: SEL_W];
				end
				OFS_IRQ_CLR: clr = wv[NUM_ALARMS-1:0];
				OFS_IRQ_EN:  next_st.irq_en = wv[NUM_ALARMS-1:0];
				default: begin
					if (wr_old[DATA_W] && win != '0) begin
						case (st.awaddr[ALM_SHIFT-1:0])
							SUB_TYPE: begin
								// Unknown codes, and loop break past the first alarm, leave the type as it was
								if (wv[DATA_W-1:CODE_W] == '0 && wv[CODE_W-1:0] <= CODE_RATE
									&& !(wv[CODE_W-1:0] == CODE_LOOP && ai != '0)) begin
									next_st.atype[ai]   = pae_code_t'(wv[CODE_W-1:0]);
									next_st.restart[ai] = 1'b1;
								end
							end
							SUB_UPPER: next_st.aupper[ai] = pae_val_t'(wv[VAL_W-1:0]);
							SUB_LOWER: next_st.alower[ai] = pae_val_t'(wv[VAL_W-1:0]);
							SUB_HYST:  next_st.ahyst[ai] = wv[VAL_W-1:0];
							SUB_PER: begin
								if (wv[DATA_W-1:PER_W] == '0 && wv[PER_W-1:0] >= PER_MIN
									&& wv[PER_W-1:0] <= PER_MAX) begin
									next_st.aper[ai] = wv[PER_W-1:0];
								end
							end
							default: next_st.aper[ai] = st.aper[ai];
						endcase
					end
				end
			endcase
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rd             = reg_read(st, s_axi_araddr, alarm_out);
			next_st.rvalid = 1'b1;
			next_st.rdata  = rd[DATA_W-1:0];
			next_st.rresp  = rd[DATA_W] ? RESP_OKAY : RESP_SLVERR;
		end
		// Sampling period divider; a long count keeps the fabric clock unrelated to the process rate
		if (st.scnt >= CNT_W'(SAMPLE_CYCLES - 1)) begin
			next_st.scnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.scnt = st.scnt + 1'b1;
		end
		if (st.tick) begin
			next_st.meas = measured_value;
		end
		// A new alarm edge wins over a clear in the same cycle
		rise             = alarm_out & ~st.alarm_d;
		next_st.alarm_d  = alarm_out;
		next_st.irq_stat = (st.irq_stat & ~clr) | rise;
		next_st.irq      = |(next_st.irq_stat & next_st.irq_en);
		for (int c = 0; c < 2; c++) begin
			if (st.co_sel[c] == '0) begin
				next_st.ctrl[c] = control_in[c];
			end else begin
				next_st.ctrl[c] = alarm_out[st.co_sel[c] - 1'b1];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			for (int i = 0; i < NUM_ALARMS; i++) begin
				st.atype[i] <= CODE_RESET;
				st.aper[i]  <= PER_RESET;
			end
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata  = st.rdata;
	assign s_axi_rresp  = st.rresp;
	assign control_out  = st.ctrl;
	assign irq          = st.irq;

	// ============================================================
	// Alarm channels
	for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
		pae_alarm_eval u_eval (
			.aclk              (aclk),
			.aresetn           (aresetn),
			.tick              (st.tick),
			.restart           (st.restart[g]),
			.code              (st.atype[g]),
			.measured_value    (measured_value),
			.target_value      (st.target),
			.upper_value       (st.aupper[g]),
			.lower_value       (st.alower[g]),
			.hysteresis        (st.ahyst[g]),
			.period            (st.aper[g]),
			.loop_break_detect (loop_break_detect),
			.alarm             (alarm_out[g])
		);
		a_period_legal: assert property (@(posedge aclk) disable iff (!aresetn)
			st.aper[g] >= PER_MIN && st.aper[g] <= PER_MAX)
			else $error("Rate period left its legal range");
		if (g != 0) begin : g_no_loop
			a_loop_first: assert property (@(posedge aclk) disable iff (!aresetn) st.atype[g] != CODE_LOOP)
				else $error("Loop break type taken by a later alarm");
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_type_reset: assert property ($past(!aresetn) |-> st.atype == {NUM_ALARMS{CODE_RESET}})
		else $error("Alarm types not at upper limit after reset");
	a_route_ctrl: assert property (st.co_sel[0] == '0 |=> control_out[0] == $past(control_in[0]))
		else $error("Control output lost its control action");
	a_route_alarm: assert property (st.co_sel[1] == SEL_W'(NUM_ALARMS) |=> control_out[1] == $past(alarm_out[NUM_ALARMS-1]))
		else $error("Control output not following its alarm");
	a_write_resp: assert property (st.aw_got && st.w_got && !st.bvalid |=> s_axi_bvalid)
		else $error("Write response missing");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data changed while stalled");
	a_irq_sticky: assert property (rise != '0 |=> (st.irq_stat & $past(rise)) == $past(rise))
		else $error("Alarm edge did not set its status bit");

	c_alarm_rise: cover property (rise != '0);
	c_irq_raise: cover property ($rose(irq));
	c_routed_on: cover property (st.co_sel[0] != '0 && control_out[0]);
	c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule

/* File: pae_alarm_top_bench.sv */
`timescale 1ns/1ps
module pae_alarm_top_bench;
	import pae_pkg::*;
	// ============================================================
	// Signals
	localparam int SC = 4;
	logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lbd;
	logic                  awready, wready, bvalid, arready, rvalid, irq;
	logic [ADDR_W-1:0]     awaddr, araddr;
	logic [DATA_W-1:0]     wdata, rdata;
	logic [STRB_W-1:0]     wstrb;
	logic [1:0]            bresp, rresp, control_in, control_out, rs;
	logic [NUM_ALARMS-1:0] alarm_out;
	pae_val_t              mv;
	logic [DATA_W-1:0]     rd_v;
	int                    err_total, n_checks;
	pae_alarm_top #(.SAMPLE_CYCLES(SC)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .measured_value(mv), .loop_break_detect(lbd), .control_in(control_in),
		.alarm_out(alarm_out), .control_out(control_out), .irq(irq));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ============================================================
	// Bus tasks; handshakes are observed mid-cycle so the edge decides
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic at, wt, bt;
		@(posedge aclk);
		awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(negedge aclk);
			at = awvalid && awready; wt = wvalid && wready; bt = bvalid; rs = bresp;
			@(posedge aclk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
			if (bt) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic art, rt;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever begin
			@(negedge aclk);
			art = arvalid && arready; rt = rvalid; rd_v = rdata; rs = rresp;
			@(posedge aclk);
			if (art) arvalid <= 1'b0;
			if (rt) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk(nm, e, rd_v);
	endtask
	// Several sample ticks pass so the alarm state has settled
	task automatic alm(input logic [15:0] m, input logic [2:0] e);
		@(posedge aclk);
		mv <= m;
		repeat (4 * SC + 4) @(posedge aclk);
		@(negedge aclk);
		chk("alarm_out", {29'h0, e}, {29'h0, alarm_out});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ============================================================
	// Tests
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		tally_and_finish;
	end
	initial begin
		aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; lbd = 1'b0; control_in = 2'b00; mv = '0;
		err_total = 0; n_checks = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int n = 1; n <= 3; n++) rchk(8'(32 * n), 32'h2, "type reset");
		rchk(8'h30, 32'h4, "period reset");
		rd(8'h1c);
		chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		wr(8'h1c, 32'h0);
		chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		wr(8'h24, 32'h0a); wr(8'h2c, 32'h2);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
		// Alarms 2 and 3 start as upper limit with a zero threshold, so they fire too
		alm(16'sd11, 3'b111);
		alm(16'sd9, 3'b111);
		alm(16'sd7, 3'b110);
		wr(8'h40, 32'h3); wr(8'h44, 32'h0a);
		alm(-16'sd11, 3'b010);
		wr(8'h60, 32'h8); wr(8'h64, 32'h5); wr(8'h00, 32'h64);
		alm(16'sd6, 3'b110);
		rchk(8'h04, 32'h6, "state");
		rchk(8'h18, 32'h6, "meas");
		wr(8'h40, 32'hc);
		rchk(8'h40, 32'h3, "type 12 on alarm 2");
		wr(8'h20, 32'hc);
		lbd <= 1'b1;
		alm(16'sd6, 3'b111);
		wr(8'h08, 32'h31);
		alm(16'sd6, 3'b111);
		chk("control_out", 32'h3, {30'h0, control_out});
		wr(8'h08, 32'h0);
		control_in <= 2'b10;
		repeat (4) @(negedge aclk);
		chk("control_out", 32'h2, {30'h0, control_out});
		rchk(8'h0c, 32'h7, "irq status");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'h14, 32'h1);
		repeat (3) @(negedge aclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h10, 32'h7);
		repeat (3) @(negedge aclk);
		rchk(8'h0c, 32'h0, "irq status cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(8'h20, 32'h0);
		alm(16'sd6, 3'b110);
		wr(8'h60, 32'ha);
		alm(16'sd6, 3'b010);
		alm(16'sd0, 3'b010);
		alm(16'sd6, 3'b110);
		// Alarm 2 as a band: upper deviation 10, lower deviation 5, target 100
		wr(8'h48, 32'h5); wr(8'h40, 32'h1);
		alm(16'sd100, 3'b100);
		alm(16'sd111, 3'b110);
		alm(16'sd94, 3'b110);
		wr(8'h40, 32'h4);
		alm(16'sd100, 3'b110);
		// Alarm 1 as rate of change, threshold 10, default period of four samples
		wr(8'h20, 32'hd);
		@(posedge aclk);
		mv <= 16'sd130;
		for (int i = 0; i < 24 && !alarm_out[0]; i++) @(negedge aclk);
		chk("rate alarm", 32'h1, {31'h0, alarm_out[0]});
		tally_and_finish;
	end
endmodule
